// File: src/usw_regs.svh
// Register offsets, field positions, reset values and bus codes of the serial wire-mode unit
`ifndef USW_REGS_SVH
`define USW_REGS_SVH

// ************************************************************
// Register byte addresses (one aligned 32-bit word each)
// ************************************************************
`define USW_AW             8
`define USW_OFS_CTRL       8'h00
`define USW_OFS_STAT       8'h04
`define USW_OFS_DATA       8'h08
`define USW_OFS_PORT       8'h0c

// ************************************************************
// Control register fields
// ************************************************************
`define USW_CTRL_SIE       7
`define USW_CTRL_OIE       6
`define USW_CTRL_WM_LO     4
`define USW_CTRL_CS_LO     2
`define USW_CTRL_CLK       1
`define USW_CTRL_TC        0

// ************************************************************
// Status register fields
// ************************************************************
`define USW_STAT_SIF       7
`define USW_STAT_OIF       6
`define USW_STAT_CNT_LO    0

// ************************************************************
// Port register fields and pin indices
// ************************************************************
`define USW_PIN_DO         0
`define USW_PIN_DI         1
`define USW_PIN_CK         2
`define USW_PORT_DIR_LO    4
`define USW_PORT_LVL_LO    8

// ************************************************************
// Reset values and bus answer codes
// ************************************************************
`define USW_RST_BYTE       8'h00
`define USW_RESP_OKAY      2'h0
`define USW_RESP_SLVERR    2'h2

`endif

// File: src/usw_pkg.sv
// Types shared by the serial wire-mode unit modules
package usw_pkg;

  // Wire mode encodings in field order
  typedef enum logic [1:0] {USW_WM_OFF, USW_WM_THREE, USW_WM_TWO, USW_WM_TWO_HOLD} usw_wire_type;

  // Whole state of the top module
  typedef struct packed {
    logic [1:0]   irq_en;    // Stored enable bits, no interrupt logic here
    usw_wire_type wm;        // Wire mode select
    logic [1:0]   cs;        // Clock source select
    logic         clksel;    // Stored strobe selection under external clock
    logic [2:0]   port;      // Port output bits per pin
    logic [2:0]   dir;       // Direction bits per pin
    logic         sif;       // Start condition flag
    logic         oif;       // Counter overflow flag
    logic         ck_prev;   // Clock pin level last cycle
    logic         sda_prev;  // Data pin level last cycle
    logic [2:0]   pin_o;     // Registered pin output values
    logic [2:0]   pin_oe;    // Registered pin output enables
    logic [2:0]   pin_pu;    // Registered pin pull-up enables
    logic         bvalid;    // Write answer pending
    logic [1:0]   bresp;     // Write answer code
    logic         rvalid;    // Read answer pending
    logic [31:0]  rdata;     // Read answer data
    logic [1:0]   rresp;     // Read answer code
  } usw_top_state_type;

  // Whole state of the shift core
  typedef struct packed {
    logic [7:0] sr;     // Shift register
    logic [3:0] cnt;    // 4-bit counter
    logic       latch;  // Data output latch
  } usw_shift_state_type;

endpackage

// File: src/usw_core_if.sv
// Interface between the control top and the shift core
`timescale 1ns/1ps
interface usw_core_if;
  logic       shift_p;     // One-cycle shift request
  logic       count_p;     // One-cycle counter increment
  logic       din;         // Sampled serial input level
  logic       latch_open;  // Output latch transparent
  logic       wr_sr_en;    // Software write of shift register
  logic [7:0] wr_sr;       // Written shift register value
  logic       wr_cnt_en;   // Software write of counter
  logic [3:0] wr_cnt;      // Written counter value
  logic [7:0] sr;          // Current shift register
  logic [3:0] cnt;         // Current counter
  logic       dout;        // Latched serial output
  logic       wrap;        // Counter wraps this cycle

  modport ctl (output shift_p, count_p, din, latch_open, wr_sr_en, wr_sr, wr_cnt_en, wr_cnt,
               input sr, cnt, dout, wrap);
  modport core (input shift_p, count_p, din, latch_open, wr_sr_en, wr_sr, wr_cnt_en, wr_cnt,
                output sr, cnt, dout, wrap);
endinterface

// File: src/usw_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module usw_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by the second
    logic [W-1:0] s2;  // Second stage, safe to use
  } usw_sync_state_type;

  usw_sync_state_type q;
  usw_sync_state_type d;

  // Shift the pins through both stages
  always_comb
  begin
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  // Register the copy
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign sync_out = q.s2;
endmodule

// File: src/usw_shift.sv
// Shift register, 4-bit counter and data output latch
`timescale 1ns/1ps
`include "usw_regs.svh"
module usw_shift (
  input  wire logic clk,
  input  wire logic rst,
  usw_core_if.core  bus
);
  // ************************************************************
  // State
  // ************************************************************
  usw_pkg::usw_shift_state_type q;
  usw_pkg::usw_shift_state_type d;
  logic                         out_bit;  // Latch output seen by pins

  // Software write wins over a shift in the same cycle
  always_comb
  begin
    d = q;
    if (bus.wr_sr_en)
      d.sr = bus.wr_sr;
    else if (bus.shift_p)
      d.sr = {q.sr[6:0], bus.din};
    if (bus.wr_cnt_en)
      d.cnt = bus.wr_cnt;
    else if (bus.count_p)
      d.cnt = 4'(q.cnt + 4'h1);
    d.latch = out_bit;
  end

  // Open latch follows the MSB, closed latch keeps the last value
  assign out_bit = bus.latch_open ? q.sr[7] : q.latch;

  // Register the copy
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign bus.sr   = q.sr;
  assign bus.cnt  = q.cnt;
  assign bus.dout = out_bit;
  assign bus.wrap = bus.count_p & ~bus.wr_cnt_en & (q.cnt == 4'hf);
endmodule

// File: src/usw_top.sv
// Wire-mode and clock-source control of the universal serial unit, with AXI4-Lite registers
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "usw_regs.svh"

// Contract
// - Mode 00: outputs, hold, start detector off
// - Three-wire: shift output replaces data port bit
// - Three-wire: input and clock pins stay port
// - Two-wire: open-drain drivers enabled by direction
// - SDA low when shift bit or port zero
// - SCL low when port zero or hold
// - Start detected holds SCL until flag cleared
// - Two-wire: pull-ups off, inputs unaffected
// - Mode 11: overflow holds SCL until cleared
// - External clock latches output on opposite edge
// - Select 00/01: strobe, none, or timer match
// - Select 1x: external edge, counter both edges
// - Strobe bit stores counter source under external
// - Strobe write shifts once and increments counter
// - Toggle write inverts clock port bit, reads zero
// - Toggle write increments counter when selected
// - Overflow flag on wrap, cleared by one
// - Start flag on start, cleared by one
module usw_top (
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  input  wire logic [`USW_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [`USW_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              TMR_MATCH,
  input  wire logic              SDIN_I,
  input  wire logic              SCLK_I,
  output logic                   SDOUT_O,
  output logic                   SDOUT_OE,
  output logic                   SDOUT_PU,
  output logic                   SDIN_O,
  output logic                   SDIN_OE,
  output logic                   SDIN_PU,
  output logic                   SCLK_O,
  output logic                   SCLK_OE,
  output logic                   SCLK_PU
);
  // ************************************************************
  // Declarations
  // ************************************************************
  usw_pkg::usw_top_state_type q;           // Registered state
  usw_pkg::usw_top_state_type d;           // Next state
  usw_core_if                 core ();     // Link to the shift core
  logic [1:0]                 pin_s;       // Synchronised {clock, data} levels
  logic                       ck_s;        // Clock pin level
  logic                       sda_s;       // Data pin level
  logic                       wr_go;       // Write address and data taken
  logic                       rd_go;       // Read address taken
  logic [7:0]                 wdat;        // Written byte
  logic                       wen_ctrl;    // Write hits control
  logic                       wen_stat;    // Write hits status
  logic                       wen_data;    // Write hits data
  logic                       wen_port;    // Write hits port
  logic                       wr_map;      // Write address is mapped
  logic                       strobe_p;    // Clock strobe pulse
  logic                       toggle_p;    // Toggle clock pulse
  logic                       ck_rise;     // Clock pin rising edge
  logic                       ck_fall;     // Clock pin falling edge
  logic                       start_p;     // Start condition seen
  logic                       two_wire;    // Either two-wire mode
  logic                       hold;        // Clock hold request
  logic [7:0]                 rd_byte;     // Read mux result
  logic                       rd_map;      // Read address is mapped

  // ************************************************************
  // Pin synchronisation and shift core
  // ************************************************************
  // Pins are foreign to MCLK, so both stages come before any edge logic
  usw_sync #(.W(2)) u_sync (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .async_in ({SCLK_I, SDIN_I}),
    .sync_out (pin_s)
  );
  assign ck_s  = pin_s[1];
  assign sda_s = pin_s[0];

  usw_shift u_shift (
    .clk (MCLK),
    .rst (SYS_RST),
    .bus (core)
  );

  // ************************************************************
  // Bus handshake and decode
  // ************************************************************
  // Address and data are taken together; one answer outstanding per channel
  assign wr_go         = S_AXI_AWVALID & S_AXI_WVALID & ~q.bvalid;
  assign rd_go         = S_AXI_ARVALID & ~q.rvalid;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign S_AXI_ARREADY = ~q.rvalid;
  assign wdat          = S_AXI_WDATA[7:0];

  // Only byte lane 0 carries register bits
  assign wen_ctrl = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == `USW_OFS_CTRL);
  assign wen_stat = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == `USW_OFS_STAT);
  assign wen_data = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == `USW_OFS_DATA);
  assign wen_port = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == `USW_OFS_PORT);
  assign wr_map   = (S_AXI_AWADDR == `USW_OFS_CTRL) | (S_AXI_AWADDR == `USW_OFS_STAT) |
                    (S_AXI_AWADDR == `USW_OFS_DATA) | (S_AXI_AWADDR == `USW_OFS_PORT);

  // Strobe counts only when the write itself selects software strobe
  assign strobe_p = wen_ctrl & wdat[`USW_CTRL_CLK] & (wdat[`USW_CTRL_CS_LO+:2] == 2'h0);
  assign toggle_p = wen_ctrl & wdat[`USW_CTRL_TC];

  // ************************************************************
  // Edge and start detection
  // ************************************************************
  assign ck_rise  = ck_s & ~q.ck_prev;
  assign ck_fall  = ~ck_s & q.ck_prev;
  assign two_wire = q.wm[1];
  // Start: data falls while clock stays high; dead in modes 00 and 01
  assign start_p  = two_wire & ~sda_s & q.sda_prev & ck_s & q.ck_prev;
  // Hold after start in both two-wire modes, after overflow only in mode 11
  assign hold     = (two_wire & q.sif) | ((q.wm == usw_pkg::USW_WM_TWO_HOLD) & q.oif);

  // ************************************************************
  // Clock source selection to the shift core
  // ************************************************************
  always_comb
  begin
    core.shift_p = 1'b0;
    core.count_p = 1'b0;
    unique case (q.cs)
      2'h0:
      begin
        // Software strobe clocks both units
        core.shift_p = strobe_p;
        core.count_p = strobe_p;
      end
      2'h1:
      begin
        // Timer compare match clocks both units
        core.shift_p = TMR_MATCH;
        core.count_p = TMR_MATCH;
      end
      2'h2:
      begin
        core.shift_p = ck_rise;
        core.count_p = q.clksel ? toggle_p : (ck_rise | ck_fall);
      end
      2'h3:
      begin
        core.shift_p = ck_fall;
        core.count_p = q.clksel ? toggle_p : (ck_rise | ck_fall);
      end
    endcase
  end

  // Internal sources keep the latch open; external opens it away from the sample edge
  assign core.latch_open = ~q.cs[1] | (q.cs[0] ? ck_s : ~ck_s);
  assign core.din        = sda_s;
  assign core.wr_sr_en   = wen_data;
  assign core.wr_sr      = wdat;
  assign core.wr_cnt_en  = wen_stat;
  assign core.wr_cnt     = wdat[`USW_STAT_CNT_LO+:4];

  // ************************************************************
  // Next state: registers, flags and pins
  // ************************************************************
  always_comb
  begin
    d          = q;
    d.ck_prev  = ck_s;
    d.sda_prev = sda_s;
    // Control register; strobe and toggle bits are never stored as such
    if (wen_ctrl)
    begin
      d.irq_en = wdat[`USW_CTRL_OIE+:2];
      d.wm     = usw_pkg::usw_wire_type'(wdat[`USW_CTRL_WM_LO+:2]);
      d.cs     = wdat[`USW_CTRL_CS_LO+:2];
      d.clksel = wdat[`USW_CTRL_CS_LO+1] & wdat[`USW_CTRL_CLK];
    end
    // Port and direction bits
    if (wen_port)
    begin
      d.port = wdat[2:0];
      d.dir  = wdat[`USW_PORT_DIR_LO+:3];
    end
    // Toggle inverts the clock port bit whatever the direction
    if (toggle_p)
      d.port[`USW_PIN_CK] = ~q.port[`USW_PIN_CK];
    // Start flag: start in two-wire, counter step otherwise; set beats clear
    d.sif = (q.sif & ~(wen_stat & wdat[`USW_STAT_SIF])) |
            (two_wire ? start_p : core.count_p);
    // Overflow flag: wrap sets, one clears; set beats clear
    d.oif = (q.oif & ~(wen_stat & wdat[`USW_STAT_OIF])) | core.wrap;

    // Default: every pin behaves as a plain port pin
    d.pin_o  = q.port;
    d.pin_oe = q.dir;
    d.pin_pu = q.port & ~q.dir;
    unique case (q.wm)
      usw_pkg::USW_WM_OFF:
      begin
        // Plain port pins, nothing else to do
        d.pin_o = q.port;
      end
      usw_pkg::USW_WM_THREE:
      begin
        // Shift output replaces the data port bit; input and clock pins untouched
        d.pin_o[`USW_PIN_DO] = core.dout;
      end
      default:
      begin
        // Both two-wire modes: open drain, never drive high, no pull-ups
        d.pin_o[`USW_PIN_DI]  = 1'b0;
        d.pin_o[`USW_PIN_CK]  = 1'b0;
        d.pin_oe[`USW_PIN_DI] = q.dir[`USW_PIN_DI] & (~core.dout | ~q.port[`USW_PIN_DI]);
        d.pin_oe[`USW_PIN_CK] = q.dir[`USW_PIN_CK] & (~q.port[`USW_PIN_CK] | hold);
        d.pin_pu[`USW_PIN_DI] = 1'b0;
        d.pin_pu[`USW_PIN_CK] = 1'b0;
      end
    endcase

    // Write answer: unmapped addresses get SLVERR
    if (wr_go)
    begin
      d.bvalid = 1'b1;
      d.bresp  = wr_map ? `USW_RESP_OKAY : `USW_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      d.bvalid = 1'b0;
    // Read answer
    if (rd_go)
    begin
      d.rvalid = 1'b1;
      d.rdata  = {24'h0, rd_byte};
      d.rresp  = rd_map ? `USW_RESP_OKAY : `USW_RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      d.rvalid = 1'b0;
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  // Strobe and toggle bits always read zero
  always_comb
  begin
    rd_map  = 1'b1;
    rd_byte = `USW_RST_BYTE;
    unique case (S_AXI_ARADDR)
      `USW_OFS_CTRL: rd_byte = {q.irq_en, q.wm, q.cs, 2'h0};
      `USW_OFS_STAT: rd_byte = {q.sif, q.oif, 2'h0, core.cnt};
      `USW_OFS_DATA: rd_byte = core.sr;
      `USW_OFS_PORT: rd_byte = {1'b0, q.dir, 1'b0, q.port};
      default:       rd_map  = 1'b0;
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      q <= '0;
    else
      q <= d;
  end

  // ************************************************************
  // Outputs, all from flip-flops except the ready signals
  // ************************************************************
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP  = q.bresp;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA  = q.rdata;
  assign S_AXI_RRESP  = q.rresp;
  assign SDOUT_O      = q.pin_o[`USW_PIN_DO];
  assign SDOUT_OE     = q.pin_oe[`USW_PIN_DO];
  assign SDOUT_PU     = q.pin_pu[`USW_PIN_DO];
  assign SDIN_O       = q.pin_o[`USW_PIN_DI];
  assign SDIN_OE      = q.pin_oe[`USW_PIN_DI];
  assign SDIN_PU      = q.pin_pu[`USW_PIN_DI];
  assign SCLK_O       = q.pin_o[`USW_PIN_CK];
  assign SCLK_OE      = q.pin_oe[`USW_PIN_CK];
  assign SCLK_PU      = q.pin_pu[`USW_PIN_CK];

  // ************************************************************
  // Assertions
  // ************************************************************
  a_off_mode_port: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (q.wm == usw_pkg::USW_WM_OFF) |=> (SCLK_O == $past(q.port[2])) && (SDOUT_OE == $past(q.dir[0])))
    else $error("mode 00 pins do not follow port bits");

  a_three_wire_out: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (q.wm == usw_pkg::USW_WM_THREE) |=> (SDOUT_O == $past(core.dout)) && (SCLK_O == $past(q.port[2])))
    else $error("three-wire data output wrong");

  a_sda_release: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (two_wire && core.dout && q.port[1]) |=> !SDIN_OE && !SDIN_O && !SDIN_PU)
    else $error("SDA not released");

  a_scl_start_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (two_wire && q.sif && q.dir[2] && !(wen_stat || wen_ctrl || wen_port)) |=> SCLK_OE [*2])
    else $error("SCL not held after start");

  a_ovf_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (q.wm == usw_pkg::USW_WM_TWO_HOLD) && q.oif && q.dir[2] |=> SCLK_OE)
    else $error("SCL not held after overflow");

  a_strobe_count: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (strobe_p && q.cs == 2'h0) |=> core.cnt == 4'($past(core.cnt) + 4'h1))
    else $error("strobe did not step counter");

  a_toggle_invert: assert property (@(posedge MCLK) disable iff (SYS_RST)
    toggle_p |=> q.port[2] != $past(q.port[2]))
    else $error("toggle did not invert clock port bit");

  a_toggle_count: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (toggle_p && q.cs[1] && q.clksel && !wen_stat) |=> core.cnt == 4'($past(core.cnt) + 4'h1))
    else $error("toggle did not step counter");

  a_ovf_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
    core.wrap |=> q.oif && core.cnt == 4'h0)
    else $error("overflow flag not set on wrap");

  a_start_sticky: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (q.sif && !wen_stat) |=> q.sif)
    else $error("start flag dropped without clear");

  a_write_answer: assert property (@(posedge MCLK) disable iff (SYS_RST)
    wr_go |=> S_AXI_BVALID && (S_AXI_BRESP == $past(wr_map ? `USW_RESP_OKAY : `USW_RESP_SLVERR)))
    else $error("write answer missing");
endmodule

// File: verif/usw_peer_model.sv
// Far-side serial peer: pulled-up wired lines and a simple bus master
`timescale 1ns/1ps
module usw_peer_model (
  input  wire logic sda_oe,
  input  wire logic sda_o,
  input  wire logic scl_oe,
  input  wire logic scl_o,
  output wire logic sda,
  output wire logic scl
);
  logic sda_low = 1'b0; // Peer pulls data line low
  logic scl_low = 1'b0; // Peer pulls clock line low
  // Wired lines with pull-ups; a released line reads high
  assign sda = ~((sda_oe & ~sda_o) | sda_low);
  assign scl = ~((scl_oe & ~scl_o) | scl_low);
  // Data line level; falling while clock high is a start
  task automatic set_sda(input logic low);
    sda_low = low;
  endtask
  // Clock pulses of 48 ns; clock stands high between frames
  task automatic pulses(input int n);
    repeat (n)
    begin
      scl_low = 1'b1;
      #24;
      scl_low = 1'b0;
      #24;
    end
  endtask
endmodule

// File: verif/usw_top_tb_top.sv
// Self-checking bench of the serial wire-mode unit
`timescale 1ns/1ps
`include "usw_regs.svh"
module usw_top_tb_top;
  logic MCLK = 1'b0, SYS_RST = 1'b1, TMR_MATCH = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic SDOUT_O, SDOUT_OE, SDOUT_PU, SDIN_O, SDIN_OE, SDIN_PU, SCLK_O, SCLK_OE, SCLK_PU;
  wire logic SDIN_I, SCLK_I;
  int n_errors = 0, checks = 0, cyc = 0;
  usw_top uut (.*);
  usw_peer_model peer (.sda_oe(SDIN_OE), .sda_o(SDIN_O), .scl_oe(SCLK_OE), .scl_o(SCLK_O), .sda(SDIN_I), .scl(SCLK_I));
  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial forever #2 MCLK = ~MCLK;
  // Ceiling far above the few hundred cycles the run needs
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write: address and data offered together, held until ready is sampled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    logic [1:0] r;
    @(posedge MCLK);
    S_AXI_AWADDR <= a; S_AXI_WDATA <= {24'h0, d}; S_AXI_AWVALID <= 1'b1; S_AXI_WVALID <= 1'b1; S_AXI_BREADY <= 1'b1;
    do begin @(negedge MCLK) ok = S_AXI_AWREADY; @(posedge MCLK); end while (!ok);
    S_AXI_AWVALID <= 1'b0; S_AXI_WVALID <= 1'b0;
    do
    begin
      @(negedge MCLK);
      ok = S_AXI_BVALID;
      r  = S_AXI_BRESP;
      @(posedge MCLK);
    end while (!ok);
    S_AXI_BREADY <= 1'b0;
    // Only the four words up to the port register are mapped
    chk("bresp", r, (a > `USW_OFS_PORT) ? `USW_RESP_SLVERR : `USW_RESP_OKAY);
  endtask
  // Read and compare data and answer code
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge MCLK);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1'b1; S_AXI_RREADY <= 1'b1;
    do begin @(negedge MCLK) ok = S_AXI_ARREADY; @(posedge MCLK); end while (!ok);
    S_AXI_ARVALID <= 1'b0;
    do
    begin
      @(negedge MCLK);
      ok = S_AXI_RVALID;
      d  = S_AXI_RDATA;
      r  = S_AXI_RRESP;
      @(posedge MCLK);
    end while (!ok);
    S_AXI_RREADY <= 1'b0;
    chk("rdata", d & m, e);
    chk("rresp", r, er);
  endtask
  // Pins follow a register write two edges later
  task automatic settle();
    repeat (6) @(posedge MCLK);
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_basic();
    rd(`USW_OFS_CTRL, 32'hff, 32'h0, `USW_RESP_OKAY);
    rd(8'h10, 32'h0, 32'h0, `USW_RESP_SLVERR);
    wr(8'h10, 8'h00);
    wr(`USW_OFS_PORT, 8'h75);
    settle();
    chk("pins", {SDOUT_O, SDOUT_OE, SDIN_O, SDIN_OE, SCLK_O, SCLK_OE}, 6'b110111);
    wr(`USW_OFS_CTRL, 8'h01);
    settle();
    chk("sclk_o", SCLK_O, 1'b0);
    rd(`USW_OFS_CTRL, 32'hff, 32'h0, `USW_RESP_OKAY);
    rd(`USW_OFS_PORT, 32'h77, 32'h71, `USW_RESP_OKAY);
  endtask
  task automatic t_strobe();
    wr(`USW_OFS_PORT, 8'h11);
    wr(`USW_OFS_DATA, 8'h80);
    wr(`USW_OFS_CTRL, 8'h10);
    settle();
    chk("sdout", {SDOUT_O, SDOUT_OE}, 2'b11);
    wr(`USW_OFS_CTRL, 8'h12);
    settle();
    chk("sdout_o", SDOUT_O, 1'b0);
    rd(`USW_OFS_DATA, 32'hff, 32'h01, `USW_RESP_OKAY);
    rd(`USW_OFS_STAT, 32'hff, 32'h81, `USW_RESP_OKAY);
    wr(`USW_OFS_CTRL, 8'h04);
    @(posedge MCLK) TMR_MATCH <= 1'b1;
    @(posedge MCLK) TMR_MATCH <= 1'b0;
    rd(`USW_OFS_STAT, 32'h0f, 32'h02, `USW_RESP_OKAY);
  endtask
  task automatic t_start();
    wr(`USW_OFS_DATA, 8'h80);
    wr(`USW_OFS_PORT, 8'h66);
    wr(`USW_OFS_STAT, 8'hc0);
    wr(`USW_OFS_CTRL, 8'h20);
    settle();
    chk("two_idle", {SDIN_OE, SCLK_OE, SCLK_PU, SDIN_PU}, 4'b0000);
    peer.set_sda(1'b1);
    settle();
    chk("scl_hold", {SCLK_OE, SCLK_O}, 2'b10);
    rd(`USW_OFS_STAT, 32'h80, 32'h80, `USW_RESP_OKAY);
    wr(`USW_OFS_STAT, 8'h80);
    settle();
    chk("scl_free", SCLK_OE, 1'b0);
    peer.set_sda(1'b0);
    wr(`USW_OFS_DATA, 8'h00);
    settle();
    chk("sda_low", {SDIN_OE, SDIN_O}, 2'b10);
  endtask
  task automatic t_ovf();
    wr(`USW_OFS_CTRL, 8'h30);
    wr(`USW_OFS_STAT, 8'hcf);
    wr(`USW_OFS_CTRL, 8'h32);
    settle();
    chk("ovf_hold", SCLK_OE, 1'b1);
    rd(`USW_OFS_STAT, 32'hff, 32'h40, `USW_RESP_OKAY);
    wr(`USW_OFS_STAT, 8'h40);
    settle();
    chk("ovf_free", SCLK_OE, 1'b0);
  endtask
  task automatic t_ext();
    wr(`USW_OFS_CTRL, 8'h08);
    wr(`USW_OFS_PORT, 8'h04);
    wr(`USW_OFS_DATA, 8'h00);
    wr(`USW_OFS_STAT, 8'hc0);
    peer.pulses(2);
    settle();
    chk("pu", {SDOUT_PU, SDIN_PU, SCLK_PU}, 3'b001);
    rd(`USW_OFS_STAT, 32'h0f, 32'h04, `USW_RESP_OKAY);
    rd(`USW_OFS_DATA, 32'hff, 32'h03, `USW_RESP_OKAY);
    wr(`USW_OFS_CTRL, 8'h0a);
    wr(`USW_OFS_CTRL, 8'h0b);
    rd(`USW_OFS_STAT, 32'h0f, 32'h05, `USW_RESP_OKAY);
    rd(`USW_OFS_CTRL, 32'hff, 32'h08, `USW_RESP_OKAY);
    // Negative edge select: one pulse shifts once and counts twice
    wr(`USW_OFS_CTRL, 8'h0c);
    peer.pulses(1);
    settle();
    rd(`USW_OFS_DATA, 32'hff, 32'h07, `USW_RESP_OKAY);
    rd(`USW_OFS_STAT, 32'h0f, 32'h07, `USW_RESP_OKAY);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
    t_basic();
    t_strobe();
    t_start();
    t_ovf();
    t_ext();
    final_report();
  end
endmodule
